//--- srms_defs.vh
`ifndef SRMS_DEFS_VH
`define SRMS_DEFS_VH

// Host register offsets (byte addresses)
`define SRMS_CTRL_OFS      8'h00
`define SRMS_STATUS_OFS    8'h04
`define SRMS_TCODE_OFS     8'h08
`define SRMS_TEMP_OFS      8'h0c
`define SRMS_FREQ1_OFS     8'h10
`define SRMS_FREQ2_OFS     8'h14
`define SRMS_DELTA_OFS     8'h18
`define SRMS_CLKDIV_OFS    8'h1c
`define SRMS_R7ORIG_OFS    8'h20
`define SRMS_R13ORIG_OFS   8'h24
`define SRMS_R5ORIG_OFS    8'h28
`define SRMS_R7MEAS_OFS    8'h2c
`define SRMS_CALTEMP_OFS   8'h30

// Control register bits
`define SRMS_CTRL_RECAL    0
`define SRMS_CTRL_TEMP     1
`define SRMS_CTRL_FREQ     2
`define SRMS_CTRL_AUTO     4
`define SRMS_CTRL_INITD    5

// Timing, in microseconds and clock rate in MHz
`define SRMS_CLK_MHZ       250
`define SRMS_T_VCO_US      1200
`define SRMS_T_AMP_US      500
`define SRMS_T_NORM_US     100
`define SRMS_T_MEAS_US     428

// Sequence entry points and readback steps
`define SRMS_IDX_RECAL     6'd0
`define SRMS_IDX_TEMP      6'd21
`define SRMS_IDX_TEMPRB    6'd23
`define SRMS_IDX_FREQ      6'd26
`define SRMS_IDX_F2RB      6'd31

// Measurement field values and positions
`define SRMS_RB_FREQ_R3    32'h0189fb43
`define SRMS_SECOND_STEP_CLOCK_DIVIDER_MEAS     12'h00a
`define SRMS_DIVMODE_MEAS  2'h2
`define SRMS_RAMP_BIT      29

// Temperature conversion: code*7.33mV - 0.699V, over 6.4mV/C, in 1/256 C
`define SRMS_VLSB_10UV     20'h002dd
`define SRMS_VOFF_10UV     20'h1110c
`define SRMS_RECIP_5_Q16   20'h03333
`define SRMS_DRIFT_Q8      24'h000a00

`endif

//--- srms_dev_model.sv
`timescale 1ns/10ps
module srms_dev_model (
    input  wire        clk,       // bench clock, times gaps and toggles the idle readback line
    input  wire        spi_clk,   // serial clock
    input  wire        spi_data,  // serial data
    input  wire        spi_le,    // load enable
    input  wire [7:0]  adc_code,  // converter result
    input  wire [15:0] cnt_a,     // first counter sample
    input  wire [15:0] cnt_b,     // second counter sample
    output wire        spi_dout   // readback
);
    reg [31:0] sh_reg = 32'h0;
    reg [31:0] words [0:127];
    int        gaps  [0:127];
    int        nw = 0;
    int        since = 0;
    int        gap_now = 0;
    bit        armed = 1;
    bit        sclk_q = 0;
    bit        tog = 0;
    bit        cnt_sel = 0;
    reg [15:0] rb_reg = 16'h0;
    int        rb_left = 0;
    bit [1:0]  ref_bits = 2'b00;

    // Outside readback the line toggles, so a stale sample never matches
    assign spi_dout = (rb_left != 0) ? rb_reg[15] : tog;

    always @(posedge clk) begin
        tog    <= ~tog;
        sclk_q <= spi_clk;
        since  <= spi_le ? 0 : since + 1;
        if (spi_le)
            armed <= 1;
        else if (spi_clk && !sclk_q && armed) begin
            gap_now <= since;
            armed   <= 0;
        end
    end

    always @(posedge spi_clk) sh_reg <= {sh_reg[30:0], spi_data};

    always @(posedge spi_le) begin
        words[nw] = sh_reg;
        gaps[nw] = gap_now;
        nw = nw + 1;
        if (sh_reg[3:0] == 4'h7)
            ref_bits = sh_reg[11:10];
        if (sh_reg[3:0] == 4'h3 && sh_reg[10:5] == 6'd26) begin
            rb_reg = cnt_sel ? cnt_b : cnt_a;
            cnt_sel = ~cnt_sel;
            rb_left = 16;
        end else if (sh_reg[3:0] == 4'h3 && sh_reg[10:5] == 6'd22) begin
            rb_reg = {8'h00, adc_code};
            rb_left = 16;
        end
    end

    always @(negedge spi_clk) begin
        if (rb_left != 0) begin
            rb_reg = rb_reg << 1;
            rb_left = rb_left - 1;
        end
    end
endmodule // srms_dev_model

//--- srms_host.v
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "srms_defs.vh"
module srms_host #(
    parameter        SPI_DIV   = 4,
    parameter        RB_BITS   = 16,
    parameter [19:0] DLY_VCO   = `SRMS_T_VCO_US * `SRMS_CLK_MHZ,
    parameter [19:0] DLY_AMP   = `SRMS_T_AMP_US * `SRMS_CLK_MHZ,
    parameter [19:0] DLY_NORM  = `SRMS_T_NORM_US * `SRMS_CLK_MHZ,
    parameter [19:0] DLY_MEAS  = `SRMS_T_MEAS_US * `SRMS_CLK_MHZ
) (
    input  wire        clk,        // 250 MHz clock
    input  wire        rst,        // Async reset, active high
    input  wire        hsel,       // AHB slave select
    input  wire [31:0] haddr,      // AHB address
    input  wire [1:0]  htrans,     // AHB transfer type
    input  wire        hwrite,     // AHB write
    input  wire [2:0]  hsize,      // AHB size
    input  wire [31:0] hwdata,     // AHB write data
    input  wire        hready,     // AHB bus ready
    output wire        hreadyout,  // AHB slave ready
    output wire        hresp,      // AHB response
    output reg  [31:0] hrdata,     // AHB read data
    output reg         spi_clk,    // Serial clock to device
    output reg         spi_data,   // Serial data to device
    output reg         spi_le,     // Load enable to device
    input  wire        spi_dout    // Serial readback from device
);
    localparam S_IDLE  = 3'd0;  // Waiting for a command
    localparam S_LOAD  = 3'd1;  // Fetch the next word
    localparam S_SHIFT = 3'd2;  // Clock out 32 bits
    localparam S_LATCH = 3'd3;  // Load enable pulse
    localparam S_READ  = 3'd4;  // Clock in the readback
    localparam S_WAIT  = 3'd5;  // Settling delay
    localparam S_NEXT  = 3'd6;  // Advance or finish

    reg  [2:0]  state_reg;
    reg  [5:0]  idx_reg;
    reg  [31:0] sh_reg;
    reg  [5:0]  bit_reg;
    reg         phase_reg;
    reg  [19:0] dly_reg;
    reg  [7:0]  div_reg;
    reg         dout_s1_reg, dout_s2_reg;
    reg  [RB_BITS-1:0] rb_reg;
    reg         auto_reg, initd_reg, pend_recal_reg;
    reg  [1:0]  op_reg;
    reg  [7:0]  tcode_reg;
    reg  signed [23:0] temp_reg, caltemp_reg;
    reg         caltemp_ok_reg;
    reg  [15:0] f1_reg, f2_reg, delta_reg;
    reg  [31:0] r7o_reg, r13o_reg, r5o_reg, r7m_reg;
    reg  [7:0]  a_addr_reg;
    reg         a_wr_reg;

    // One tick per serial half-period
    wire tick = (div_reg == SPI_DIV - 1);

    // Step table: {last, readback, delay[2:0], source[2:0], word}
    // Delay codes: 1 oscillator, 2 amplitude, 3 normal, 4 measurement
    // Source 0 takes the word from the table, others a stored word or one built from it
    function [39:0] step;
        input [5:0] i;
        begin
            case (i)
                6'd0:  step = {5'b00000, 3'd0, 32'h800fe500};
                6'd1:  step = {5'b00000, 3'd0, 32'h2a20b929};
                6'd2:  step = {5'b00000, 3'd0, 32'h01800827};
                6'd3:  step = {5'b00000, 3'd0, 32'h00000006};
                6'd4:  step = {5'b00000, 3'd0, 32'h01e38005};
                6'd5:  step = {5'b00000, 3'd0, 32'h00000004};
                6'd6:  step = {5'b00000, 3'd0, 32'h01897803};
                6'd7:  step = {5'b00000, 3'd0, 32'h00020642};
                6'd8:  step = {5'b00000, 3'd0, 32'hfff7ffe1};
                6'd9:  step = {5'b00001, 3'd0, 32'h800fe700};
                6'd10: step = {5'b00000, 3'd0, 32'h800fe560};
                6'd11: step = {5'b00010, 3'd0, 32'h800fed60};
                6'd12: step = {5'b00000, 3'd0, 32'h800fe5a0};
                6'd13: step = {5'b00010, 3'd0, 32'h800ff5a0};
                6'd14: step = {5'b00000, 3'd0, 32'h2800b929};
                6'd15: step = {5'b00000, 3'd0, 32'h0100a027};
                6'd16: step = {5'b00000, 3'd0, 32'h00000006};
                6'd17: step = {5'b00000, 3'd0, 32'h00f04005};
                6'd18: step = {5'b00000, 3'd0, 32'h00002004};
                6'd19: step = {5'b00011, 3'd0, 32'h0189f803};
                6'd20: step = {5'b10000, 3'd0, 32'h0000010b};
                6'd21: step = {5'b00000, 3'd0, 32'h00012064};
                6'd22: step = {5'b00000, 3'd0, 32'h0002a802};
                6'd23: step = {5'b01000, 3'd0, 32'h0189fac3};
                6'd24: step = {5'b00000, 3'd0, 32'h00002064};
                6'd25: step = {5'b10000, 3'd0, 32'h00020642};
                6'd26: step = {5'b01000, 3'd0, `SRMS_RB_FREQ_R3};
                6'd27: step = {5'b00000, 3'd1, 32'h00000000};
                6'd28: step = {5'b00000, 3'd2, 32'h00000000};
                6'd29: step = {5'b00000, 3'd3, 32'h00000000};
                6'd30: step = {5'b00100, 3'd4, 32'h00000000};
                6'd31: step = {5'b01000, 3'd0, `SRMS_RB_FREQ_R3};
                6'd32: step = {5'b00000, 3'd5, 32'h00000000};
                6'd33: step = {5'b00000, 3'd6, 32'h00000000};
                6'd34: step = {5'b10000, 3'd7, 32'h00000000};
                default: step = {5'b10000, 3'd0, 32'h00000000};
            endcase
        end
    endfunction

    wire [39:0] cur = step(idx_reg);
    wire [31:0] r13_second_step_clock_divider = {r13o_reg[31:19], `SRMS_SECOND_STEP_CLOCK_DIVIDER_MEAS, r13o_reg[6:0]};
    reg  [31:0] word;
    reg  [19:0] dly_sel;

    // Measurement words are built from what software stored beforehand
    always @* begin
        case (cur[34:32])
            3'd1: word = r7m_reg;
            3'd2: word = r13_second_step_clock_divider;
            3'd3: word = r5o_reg & ~(32'h00000001 << `SRMS_RAMP_BIT);
            3'd4: word = {r13_second_step_clock_divider[31:21], `SRMS_DIVMODE_MEAS, r13_second_step_clock_divider[18:0]};
            3'd5: word = r13o_reg;
            3'd6: word = r7o_reg;
            3'd7: word = r5o_reg;
            default: word = cur[31:0];
        endcase
        case (cur[37:35])
            3'd1: dly_sel = DLY_VCO;
            3'd2: dly_sel = DLY_AMP;
            3'd3: dly_sel = DLY_NORM;
            3'd4: dly_sel = DLY_MEAS;
            default: dly_sel = 20'h00000;
        endcase
    end

    // Temperature in 1/256 C; divide by 5 approximated by a Q16 reciprocal
    wire signed [39:0] mv_x = $signed({20'h00000, tcode_reg * `SRMS_VLSB_10UV})
                              - $signed({20'h00000, `SRMS_VOFF_10UV});
    wire signed [39:0] t_prod = (mv_x * 40'sd2) * $signed({20'h00000, `SRMS_RECIP_5_Q16});
    wire signed [23:0] temp_now = t_prod[39:16];
    wire signed [23:0] drift = temp_reg - caltemp_reg;
    wire drift_hit = (drift >= $signed(`SRMS_DRIFT_Q8)) ||
                     (drift <= -$signed(`SRMS_DRIFT_Q8));
    // New reading against the calibration point, before it is stored
    wire signed [23:0] drift_new = temp_now - caltemp_reg;
    wire drift_new_hit = (drift_new >= $signed(`SRMS_DRIFT_Q8)) ||
                         (drift_new <= -$signed(`SRMS_DRIFT_Q8));
    wire [15:0] delta_now = f2_reg - f1_reg;  // Wraps mod 2^16 on its own
    // Divider in force while counting, not the one restored afterwards
    wire [31:0] clkdiv = {8'h00, `SRMS_SECOND_STEP_CLOCK_DIVIDER_MEAS, r7m_reg[23:12]};

    // AHB-Lite slave, zero wait states, always OKAY
    // Read data registered at the address phase stands through the data phase
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    wire   a_valid   = hsel && hready && htrans[1];
    wire   wr_ctrl   = a_wr_reg && (a_addr_reg == `SRMS_CTRL_OFS);
    wire   busy      = (state_reg != S_IDLE);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            a_wr_reg   <= 1'b0;
            a_addr_reg <= 8'h00;
            hrdata     <= 32'h00000000;
        end else begin
            a_wr_reg   <= a_valid && hwrite;
            a_addr_reg <= haddr[7:0];
            if (a_valid && !hwrite) begin
                case (haddr[7:0])
                    `SRMS_CTRL_OFS:    hrdata <= {26'h0, initd_reg, auto_reg, 4'h0};
                    `SRMS_STATUS_OFS:  hrdata <= {24'h0, idx_reg, op_reg == 2'd1, busy};
                    `SRMS_TCODE_OFS:   hrdata <= {24'h0, tcode_reg};
                    `SRMS_TEMP_OFS:    hrdata <= {{8{temp_reg[23]}}, temp_reg};
                    `SRMS_FREQ1_OFS:   hrdata <= {16'h0, f1_reg};
                    `SRMS_FREQ2_OFS:   hrdata <= {16'h0, f2_reg};
                    `SRMS_DELTA_OFS:   hrdata <= {16'h0, delta_reg};
                    `SRMS_CLKDIV_OFS:  hrdata <= clkdiv;
                    `SRMS_R7ORIG_OFS:  hrdata <= r7o_reg;
                    `SRMS_R13ORIG_OFS: hrdata <= r13o_reg;
                    `SRMS_R5ORIG_OFS:  hrdata <= r5o_reg;
                    `SRMS_R7MEAS_OFS:  hrdata <= r7m_reg;
                    `SRMS_CALTEMP_OFS: hrdata <= {{8{caltemp_reg[23]}}, caltemp_reg};
                    default:           hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Stored device words; software loads them before a measurement
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            r7o_reg  <= 32'h00000000;
            r13o_reg <= 32'h00000000;
            r5o_reg  <= 32'h00000000;
            r7m_reg  <= 32'h00000000;
            auto_reg <= 1'b0;
            initd_reg <= 1'b0;
        end else if (a_wr_reg) begin
            case (a_addr_reg)
                `SRMS_CTRL_OFS: begin
                    auto_reg  <= hwdata[`SRMS_CTRL_AUTO];
                    initd_reg <= hwdata[`SRMS_CTRL_INITD];
                end
                `SRMS_R7ORIG_OFS:  r7o_reg  <= hwdata;
                `SRMS_R13ORIG_OFS: r13o_reg <= hwdata;
                `SRMS_R5ORIG_OFS:  r5o_reg  <= hwdata;
                `SRMS_R7MEAS_OFS:  r7m_reg  <= hwdata;
                default: ;
            endcase
        end
    end

    // Readback pin crosses in from the device
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dout_s1_reg <= 1'b0;
            dout_s2_reg <= 1'b0;
            div_reg     <= 8'h00;
        end else begin
            dout_s1_reg <= spi_dout;
            dout_s2_reg <= dout_s1_reg;
            // Held at zero while idle so the first frame of a run starts in phase
            div_reg     <= (tick || !busy) ? 8'h00 : div_reg + 8'h01;
        end
    end

    // Sequencer: one table step per frame, then its delay
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= S_IDLE;
            idx_reg   <= 6'd0;
            sh_reg    <= 32'h00000000;
            bit_reg   <= 6'd0;
            phase_reg <= 1'b0;
            dly_reg   <= 20'h00000;
            rb_reg    <= {RB_BITS{1'b0}};
            spi_clk   <= 1'b0;
            spi_data  <= 1'b0;
            spi_le    <= 1'b0;
            op_reg    <= 2'd0;
            pend_recal_reg <= 1'b0;
            tcode_reg <= 8'h00;
            temp_reg  <= 24'h000000;
            caltemp_reg <= 24'h000000;
            caltemp_ok_reg <= 1'b0;
            f1_reg    <= 16'h0000;
            f2_reg    <= 16'h0000;
            delta_reg <= 16'h0000;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (pend_recal_reg) begin
                        pend_recal_reg <= 1'b0;
                        op_reg    <= 2'd1;
                        idx_reg   <= `SRMS_IDX_RECAL;
                        state_reg <= S_LOAD;
                    end else if (wr_ctrl && hwdata[`SRMS_CTRL_TEMP]) begin
                        op_reg    <= 2'd2;
                        idx_reg   <= `SRMS_IDX_TEMP;
                        state_reg <= S_LOAD;
                    end else if (wr_ctrl && hwdata[`SRMS_CTRL_FREQ]) begin
                        op_reg    <= 2'd3;
                        idx_reg   <= `SRMS_IDX_FREQ;
                        state_reg <= S_LOAD;
                    end
                end
                // First bit goes out with the clock low
                S_LOAD: begin
                    sh_reg    <= word;
                    spi_data  <= word[31];
                    bit_reg   <= 6'd0;
                    phase_reg <= 1'b0;
                    state_reg <= S_SHIFT;
                end
                S_SHIFT: if (tick) begin
                    phase_reg <= ~phase_reg;
                    spi_clk   <= ~phase_reg;
                    if (phase_reg) begin
                        if (bit_reg == 6'd31) begin
                            state_reg <= S_LATCH;
                        end else begin
                            sh_reg   <= {sh_reg[30:0], 1'b0};
                            spi_data <= sh_reg[30];
                            bit_reg  <= bit_reg + 6'd1;
                        end
                    end
                end
                S_LATCH: if (tick) begin
                    spi_le <= ~spi_le;
                    if (spi_le) begin
                        // Frame closed; the delay is loaded now and counts down after any readback
                        spi_data  <= 1'b0;
                        bit_reg   <= 6'd0;
                        phase_reg <= 1'b0;
                        dly_reg   <= dly_sel;
                        state_reg <= cur[38] ? S_READ : S_WAIT;
                    end
                end
                // Sample just before the falling edge; the device shifts on it
                S_READ: if (tick) begin
                    phase_reg <= ~phase_reg;
                    spi_clk   <= ~phase_reg;
                    if (phase_reg) begin
                        rb_reg  <= {rb_reg[RB_BITS-2:0], dout_s2_reg};
                        bit_reg <= bit_reg + 6'd1;
                        if (bit_reg == RB_BITS - 1)
                            state_reg <= S_WAIT;
                    end
                end
                // Results are taken once the readback frame is over
                S_WAIT: begin
                    if (idx_reg == `SRMS_IDX_TEMPRB && cur[38] && dly_reg == 20'h0)
                        tcode_reg <= rb_reg[7:0];
                    if (idx_reg == `SRMS_IDX_FREQ && dly_reg == 20'h0)
                        f1_reg <= rb_reg[15:0];
                    if (idx_reg == `SRMS_IDX_F2RB && dly_reg == 20'h0)
                        f2_reg <= rb_reg[15:0];
                    if (dly_reg == 20'h0)
                        state_reg <= S_NEXT;
                    else
                        dly_reg <= dly_reg - 20'h00001;
                end
                // Calibration point is the last reading before the run
                S_NEXT: begin
                    if (cur[39]) begin
                        state_reg <= S_IDLE;
                        if (op_reg == 2'd1) begin
                            caltemp_reg    <= temp_reg;
                            caltemp_ok_reg <= 1'b1;
                        end
                        if (op_reg == 2'd2) begin
                            temp_reg <= temp_now;
                            if (auto_reg && initd_reg && caltemp_ok_reg && drift_new_hit)
                                pend_recal_reg <= 1'b1;
                        end
                        if (op_reg == 2'd3)
                            delta_reg <= delta_now;
                        op_reg <= 2'd0;
                    end else begin
                        idx_reg   <= idx_reg + 6'd1;
                        state_reg <= S_LOAD;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
            // Placed last so a new request wins over taking the pending one
            if (wr_ctrl && hwdata[`SRMS_CTRL_RECAL] && initd_reg)
                pend_recal_reg <= 1'b1;
        end
    end

    // Transfer size ignored: only whole words are served
    wire unused_ok = drift_hit ^ (|hsize);
endmodule // srms_host

//--- srms_host_sva.sv
`timescale 1ns/10ps
module srms_host_sva #(
    parameter SPI_DIV = 4
) (
    input wire        clk,        // clock
    input wire        rst,        // reset
    input wire        hsel,       // select
    input wire [31:0] haddr,      // address
    input wire [1:0]  htrans,     // transfer
    input wire        hwrite,     // write
    input wire [2:0]  hsize,      // size
    input wire [31:0] hwdata,     // write data
    input wire        hready,     // bus ready
    input wire        hreadyout,  // slave ready
    input wire        hresp,      // response
    input wire [31:0] hrdata,     // read data
    input wire        spi_clk,    // serial clock
    input wire        spi_data,   // serial data
    input wire        spi_le,     // load enable
    input wire        spi_dout    // readback
);
    reg [5:0] rise_cnt;
    reg       sclk_q;
    reg       rd_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Readback pulses follow the latch, so a frame counts 32 or 48 rises
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rise_cnt <= 6'h00;
            sclk_q   <= 1'b0;
            rd_q     <= 1'b0;
        end else begin
            sclk_q <= spi_clk;
            rd_q   <= hsel && hready && htrans[1] && !hwrite;
            if (spi_le)
                rise_cnt <= 6'h00;
            else if (spi_clk && !sclk_q)
                rise_cnt <= rise_cnt + 6'h01;
        end
    end

    AST_HRESP_OKAY: assert property (hresp == 1'b0)
        else $error("slave response not OKAY");
    AST_ZERO_WAIT: assert property (hreadyout == 1'b1)
        else $error("slave inserted a wait state");
    AST_RDATA_HOLD: assert property (!rd_q |-> $stable(hrdata))
        else $error("read data changed without a read");
    AST_FRAME_BITS: assert property ($rose(spi_le) |-> rise_cnt == 6'd32 || rise_cnt == 6'd48)
        else $error("frame latched with wrong bit count");
    AST_LE_PULSE: assert property ($rose(spi_le) |-> spi_le[*4] ##1 !spi_le)
        else $error("load enable pulse width wrong");
    AST_LE_CLK_LOW: assert property (spi_le |-> !spi_clk)
        else $error("serial clock high during load enable");
    AST_SCLK_HIGH: assert property ($rose(spi_clk) |-> spi_clk[*4] ##1 !spi_clk)
        else $error("serial clock high phase wrong");
    AST_SCLK_LOW: assert property ($fell(spi_clk) |-> !spi_clk[*4])
        else $error("serial clock low phase too short");
    AST_DATA_HOLD: assert property (spi_clk |-> $stable(spi_data))
        else $error("serial data moved while clock high");

    cover property ($rose(spi_le));
    cover property ($rose(spi_le) && rise_cnt == 6'd48);
    cover property (rd_q);
endmodule // srms_host_sva

bind srms_host srms_host_sva #(.SPI_DIV(SPI_DIV)) u_srms_host_sva (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .spi_clk(spi_clk), .spi_data(spi_data), .spi_le(spi_le),
    .spi_dout(spi_dout));

//--- srms_host_tb_top.sv
`timescale 1ns/10ps
`include "srms_defs.vh"
module srms_host_tb_top;
    logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, spi_clk, spi_data, spi_le, spi_dout;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  adc_code;
    logic [15:0] cnt_a, cnt_b;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          nb, i, k;
    logic [31:0] rc [0:20] = '{32'h800fe500, 32'h2a20b929, 32'h01800827, 32'h00000006,
        32'h01e38005, 32'h00000004, 32'h01897803, 32'h00020642, 32'hfff7ffe1, 32'h800fe700,
        32'h800fe560, 32'h800fed60, 32'h800fe5a0, 32'h800ff5a0, 32'h2800b929, 32'h0100a027,
        32'h00000006, 32'h00f04005, 32'h00002004, 32'h0189f803, 32'h0000010b};
    logic [31:0] tw [0:4] = '{32'h00012064, 32'h0002a802, 32'h0189fac3, 32'h00002064, 32'h00020642};
    logic [31:0] fw [0:8] = '{32'h0189fb43, 32'h0180a027, 32'h0018050d, 32'h00f04005,
        32'h0010050d, 32'h0189fb43, 32'h0018800d, 32'h0100a027, 32'h20f04005};

    assign hready = hreadyout;

    srms_host #(.SPI_DIV(4), .DLY_VCO(20'd40), .DLY_AMP(20'd30),
                .DLY_NORM(20'd20), .DLY_MEAS(20'd50)) u_srms_host (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .spi_clk(spi_clk), .spi_data(spi_data), .spi_le(spi_le),
        .spi_dout(spi_dout));

    srms_dev_model u_srms_dev_model (.clk(clk), .spi_clk(spi_clk), .spi_data(spi_data),
        .spi_le(spi_le), .adc_code(adc_code), .cnt_a(cnt_a), .cnt_b(cnt_b), .spi_dout(spi_dout));

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        d = hrdata;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    // Polls busy; the watchdog ends a hang
    task automatic wait_idle;
        xfer(1'b0, `SRMS_STATUS_OFS, 32'h0);
        while (d[0] !== 1'b0) xfer(1'b0, `SRMS_STATUS_OFS, 32'h0);
    endtask

    task automatic run_temp(input logic [7:0] code, input logic [31:0] ctrl, input int extra);
        adc_code <= code;
        nb = u_srms_dev_model.nw;
        xfer(1'b1, `SRMS_CTRL_OFS, ctrl);
        wait_idle;
        // A drift-triggered run starts one cycle after the temperature run ends
        repeat (4) @(posedge clk);
        wait_idle;
        for (i = 0; i < 5; i++) chk("temp word", tw[i], u_srms_dev_model.words[nb + i]);
        chk("word count", 32'(5 + extra), 32'(u_srms_dev_model.nw - nb));
    endtask

    task automatic report_and_stop;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        report_and_stop;
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        adc_code = 8'h7b;
        cnt_a = 16'hfff0;
        cnt_b = 16'h0010;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        xfer(1'b0, `SRMS_STATUS_OFS, 32'h0);
        chk("status reset", 32'h0, d);
        xfer(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, d);
        // Recalibration must be refused before initialization is flagged
        xfer(1'b1, `SRMS_CTRL_OFS, 32'h1);
        wait_idle;
        chk("refused recal", 32'h0, 32'(u_srms_dev_model.nw));
        xfer(1'b1, `SRMS_CTRL_OFS, 32'h20);
        xfer(1'b1, `SRMS_CTRL_OFS, 32'h21);
        wait_idle;
        chk("recal count", 32'd21, 32'(u_srms_dev_model.nw));
        for (i = 0; i < 21; i++) chk("recal word", rc[i], u_srms_dev_model.words[i]);
        chk("vco gap", 32'h1, {31'h0, u_srms_dev_model.gaps[10] >= 40});
        chk("amp1 gap", 32'h1, {31'h0, u_srms_dev_model.gaps[12] >= 30});
        chk("amp2 gap", 32'h1, {31'h0, u_srms_dev_model.gaps[14] >= 30});
        chk("norm gap", 32'h1, {31'h0, u_srms_dev_model.gaps[20] >= 20});
        chk("ref bits", 32'h0, {30'h0, u_srms_dev_model.ref_bits});
        run_temp(8'h7b, 32'h22, 0);
        xfer(1'b0, `SRMS_TCODE_OFS, 32'h0);
        chk("temp code", 32'h7b, d);
        xfer(1'b0, `SRMS_TEMP_OFS, 32'h0);
        chk("temp range", 32'h1, {31'h0, d > 32'd8000 && d < 32'd8200});
        xfer(1'b1, `SRMS_CTRL_OFS, 32'h31);
        wait_idle;
        run_temp(8'h7f, 32'h32, 0);
        run_temp(8'h8a, 32'h32, 21);
        xfer(1'b1, `SRMS_R7ORIG_OFS, 32'h0100a027);
        xfer(1'b1, `SRMS_R13ORIG_OFS, 32'h0018800d);
        xfer(1'b1, `SRMS_R5ORIG_OFS, 32'h20f04005);
        xfer(1'b1, `SRMS_R7MEAS_OFS, 32'h0180a027);
        for (k = 0; k < 2; k++) begin
            cnt_a <= (k == 1) ? 16'h0100 : 16'hfff0;
            cnt_b <= (k == 1) ? 16'h0400 : 16'h0010;
            nb = u_srms_dev_model.nw;
            xfer(1'b1, `SRMS_CTRL_OFS, 32'h24);
            wait_idle;
            for (i = 0; i < 9; i++) chk("freq word", fw[i], u_srms_dev_model.words[nb + i]);
            chk("meas gap", 32'h1, {31'h0, u_srms_dev_model.gaps[nb + 5] >= 50});
            xfer(1'b0, `SRMS_FREQ2_OFS, 32'h0);
            chk("second sample", {16'h0, cnt_b}, d);
            xfer(1'b0, `SRMS_DELTA_OFS, 32'h0);
            chk("delta", (k == 1) ? 32'h300 : 32'h20, d);
        end
        xfer(1'b0, `SRMS_FREQ1_OFS, 32'h0);
        chk("first sample", 32'h0100, d);
        xfer(1'b0, `SRMS_CLKDIV_OFS, 32'h0);
        chk("clkdiv", 32'h0000a80a, d);
        report_and_stop;
    end
endmodule // srms_host_tb_top
